// [rtl/sdp_params.svh]
// timing counts, offsets, field positions and reset values of the synthesizer
`ifndef SDP_PARAMS_SVH
`define SDP_PARAMS_SVH

`define SDP_CLK_PERIOD_NS 10
`define SDP_PULSE_NS 50
`define SDP_PULSE_CYC ((`SDP_PULSE_NS + `SDP_CLK_PERIOD_NS - 1) / `SDP_CLK_PERIOD_NS)

`define SDP_REF_WIDTH 15
`define SDP_FB_WIDTH 16

`define SDP_OFF_CONFIG 8'h00
`define SDP_OFF_REF_DIV 8'h04
`define SDP_OFF_FB_DIV 8'h08
`define SDP_OFF_STATUS 8'h0C
`define SDP_OFF_REF_CNT 8'h10
`define SDP_OFF_FB_CNT 8'h14
`define SDP_OFF_SHIFT 8'h18

`define SDP_CFG_INVERT 7
`define SDP_CFG_SELECT 6
`define SDP_CFG_REFSEL_HI 4
`define SDP_CFG_REFSEL_LO 2
`define SDP_CFG_FB_EN 1
`define SDP_CFG_REF_EN 0

`define SDP_CFG_RESET 8'h10
`define SDP_REF_DIV_RESET 15'h0005
`define SDP_FB_DIV_RESET 16'h0028

`define SDP_SHIFT_LEN 17

`endif

// [rtl/sdp_pkg.sv]
// types shared by the divider and phase detector design
package sdp_pkg;

	typedef enum logic [2:0] {
		SDP_REF_LOW,
		SDP_REF_DIV1,
		SDP_REF_DIV2,
		SDP_REF_DIV4,
		SDP_REF_DIV8,
		SDP_REF_DIV16,
		SDP_REF_DIV8B,
		SDP_REF_DIV16B
	} sdp_refsel_e;

	typedef enum logic [1:0] {
		SDP_PD_IDLE,
		SDP_PD_REF_LEAD,
		SDP_PD_FB_LEAD
	} sdp_pd_e;

	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] addr;
	} sdp_addr_phase_s;

	typedef struct packed {
		logic invert;
		logic select;
		logic spare;
		sdp_refsel_e refsel;
		logic fb_en;
		logic ref_en;
	} sdp_config_s;

endpackage : sdp_pkg

// [rtl/sdp_pin_sync.sv]
// three-stage pin synchroniser with edge events
`timescale 1ns/1ns
`default_nettype none

module sdp_pin_sync
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic pin,
	output logic level,
	output logic rise,
	output logic fall
);

	logic s1;
	logic s2;
	logic s3;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end
		else
		begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
		end
	end

	assign level = s3;
	assign rise = s2 & ~s3;
	assign fall = ~s2 & s3;

endmodule : sdp_pin_sync

`default_nettype wire

// [rtl/sdp_divider.sv]
// programmable down counter with reload and stretched divided pulse
`timescale 1ns/1ns
`default_nettype none

module sdp_divider
#(
	parameter int WIDTH = 16,
	parameter int PULSE_CYC = 5
)
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic tick,
	input wire logic jam,
	input wire logic [WIDTH-1:0] ratio,
	output logic [WIDTH-1:0] count,
	output logic event_out,
	output logic pulse
);

	localparam logic [WIDTH-1:0] ONE = WIDTH'(1);
	localparam logic [7:0] PW = 8'(PULSE_CYC);

	logic [7:0] pw_cnt;
	wire terminal = tick & (count <= ONE);

	// each edge outside a jam cycle takes exactly one count, reload at terminal
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			count <= ONE;
		else if (jam)
			count <= ratio;
		else if (terminal)
			count <= ratio;
		else if (tick)
			count <= count - ONE;
	end

	assign event_out = terminal & ~jam;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			pw_cnt <= 8'h00;
		// a pulse already begun stands its full width across a jam
		else if (event_out)
			pw_cnt <= PW;
		else if (pw_cnt != 8'h00)
			pw_cnt <= pw_cnt - 8'h01;
	end

	assign pulse = (pw_cnt != 8'h00);

endmodule : sdp_divider

`default_nettype wire

// [rtl/sdp_synth_core.sv]
// divider, reference output and phase detector core with AHB-Lite registers
`timescale 1ns/1ns
`default_nettype none
`include "sdp_params.svh"

// What this block does
// RL1 - serial output shifts next bit on falling clock
// RL2 - reference edge decrements reference counter once
// RL3 - VCO edge decrements feedback counter once
// RL4 - counters static, any slow edge rate works
// RL5 - reference output starts at divide by eight
// RL6 - config enables, disables or scales reference output
// RL7 - controller avoids divide-by-one above 10 MHz
// RL8 - 15-stage reference counter, pulse low until enabled
// RL9 - reference ratio equals value, one passes through
// RL10 - 16-stage feedback counter, pulse low until enabled
// RL11 - feedback ratio equals programmed value
// RL12 - divided pulses rest low, pulse high once
// RL13 - controller keeps divided pulses under 2 MHz
// RL14 - error polarity follows lead, invert swaps it
// RL15 - matched edges leave error output undriven
// RL16 - no dead zone, width tracks difference
// RL17 - error output enable, invert or disable
// RL18 - three-bit select picks reference output rate
// RL19 - separate enables gate both divided pulses
// RL20 - select bit enables single-ended error output
// RL21 - feedback write jam-loads both counters together
// RL22 - reload at terminal, one pulse each cycle
// RL23 - earlier edge drives error until later edge
module sdp_synth_core
#(
	parameter int REF_WIDTH = `SDP_REF_WIDTH,
	parameter int FB_WIDTH = `SDP_FB_WIDTH,
	parameter int PULSE_CYC = `SDP_PULSE_CYC
)
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic ref_osc_input,
	input wire logic vco_input,
	input wire logic ser_clk,
	input wire logic ser_din,
	input wire logic ser_enable_n,
	output logic ser_dout_o,
	output logic ser_dout_oe_n,
	output logic ref_clock_output,
	output logic ref_divided_pulse,
	output logic feedback_divided_pulse,
	output logic phase_error_output_o,
	output logic phase_error_output_oe_n
);

	// ---------------- pin synchronisers ----------------
	localparam int NPIN = 5;
	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] pin_lvl;
	logic [NPIN-1:0] pin_rise;
	logic [NPIN-1:0] pin_fall;

	// enable goes in inverted so a cleared synchroniser reads idle high
	assign pin_raw = {~ser_enable_n, ser_din, ser_clk, vco_input,
		ref_osc_input};

	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++)
		begin : g_sync
			sdp_pin_sync u_sync
			(
				.mclk(mclk),
				.rst(rst),
				.pin(pin_raw[gi]),
				.level(pin_lvl[gi]),
				.rise(pin_rise[gi]),
				.fall(pin_fall[gi])
			);
		end
	endgenerate

	wire ref_lvl = pin_lvl[0];
	wire ref_tick = pin_rise[0];
	wire vco_tick = pin_rise[1];
	wire sclk_rise = pin_rise[2];
	wire sclk_fall = pin_fall[2];
	wire sdin_lvl = pin_lvl[3];
	wire senb_n = ~pin_lvl[4];

	// ---------------- AHB-Lite slave ----------------
	sdp_pkg::sdp_addr_phase_s aph;
	sdp_pkg::sdp_config_s cfg;
	logic [REF_WIDTH-1:0] ref_ratio;
	logic [FB_WIDTH-1:0] fb_ratio;
	logic [REF_WIDTH-1:0] ref_count;
	logic [FB_WIDTH-1:0] fb_count;
	logic [`SDP_SHIFT_LEN-1:0] shift_reg;
	sdp_pkg::sdp_pd_e pd_state;

	wire addr_take = hsel & htrans[1] & hready;
	wire wr_cycle = aph.valid & aph.write;
	wire wr_config = wr_cycle & (aph.addr == `SDP_OFF_CONFIG);
	wire wr_ref = wr_cycle & (aph.addr == `SDP_OFF_REF_DIV);
	wire wr_fb = wr_cycle & (aph.addr == `SDP_OFF_FB_DIV);
	wire jam = wr_fb;

	// zero wait states, errors never raised
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			aph <= '0;
		else if (hready)
		begin
			aph.valid <= addr_take;
			aph.write <= hwrite;
			aph.addr <= {haddr[7:2], 2'b00};
		end
	end

	function automatic logic [31:0] read_mux(input logic [7:0] a,
		input logic [31:0] cfg_w, input logic [31:0] ref_w,
		input logic [31:0] fb_w, input logic [31:0] st_w,
		input logic [31:0] rc_w, input logic [31:0] fc_w,
		input logic [31:0] sh_w);
		logic [31:0] r;
		r = 32'h0000_0000;
		case (a)
			`SDP_OFF_CONFIG: r = cfg_w;
			`SDP_OFF_REF_DIV: r = ref_w;
			`SDP_OFF_FB_DIV: r = fb_w;
			`SDP_OFF_STATUS: r = st_w;
			`SDP_OFF_REF_CNT: r = rc_w;
			`SDP_OFF_FB_CNT: r = fc_w;
			`SDP_OFF_SHIFT: r = sh_w;
			default: r = 32'h0000_0000;
		endcase
		return r;
	endfunction : read_mux

	wire [31:0] status_word = {24'h00_0000, 1'b0, ser_dout_oe_n,
		phase_error_output_oe_n, phase_error_output_o,
		feedback_divided_pulse, ref_divided_pulse, ref_clock_output,
		senb_n};
	wire [31:0] rd_word = read_mux({haddr[7:2], 2'b00},
		{24'h00_0000, cfg},
		{{(32 - REF_WIDTH){1'b0}}, ref_ratio},
		{{(32 - FB_WIDTH){1'b0}}, fb_ratio},
		status_word,
		{{(32 - REF_WIDTH){1'b0}}, ref_count},
		{{(32 - FB_WIDTH){1'b0}}, fb_count},
		{{(32 - `SDP_SHIFT_LEN){1'b0}}, shift_reg});

	// read data registered in the address phase for a zero-wait reply
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			hrdata <= 32'h0000_0000;
		else if (addr_take & ~hwrite)
			hrdata <= rd_word;
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			cfg <= sdp_pkg::sdp_config_s'(`SDP_CFG_RESET); // see RL5 see RL19
		else if (wr_config)
			cfg <= sdp_pkg::sdp_config_s'(hwdata[7:0]); // see RL6 see RL17
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			ref_ratio <= REF_WIDTH'(`SDP_REF_DIV_RESET);
		else if (wr_ref)
			ref_ratio <= hwdata[REF_WIDTH-1:0]; // see RL9
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			fb_ratio <= FB_WIDTH'(`SDP_FB_DIV_RESET);
		else if (wr_fb)
			fb_ratio <= hwdata[FB_WIDTH-1:0]; // see RL11
	end

	// ---------------- counters ----------------
	logic ref_event;
	logic fb_event;
	logic ref_pulse_raw;
	logic fb_pulse_raw;

	// jam takes the new feedback value straight off the bus
	wire [FB_WIDTH-1:0] fb_load = wr_fb ? hwdata[FB_WIDTH-1:0] : fb_ratio;

	// counters run off synchronised edges only, so no minimum rate
	sdp_divider #(.WIDTH(REF_WIDTH), .PULSE_CYC(PULSE_CYC)) u_ref_div
	(
		.mclk(mclk),
		.rst(rst),
		.tick(ref_tick), // see RL2 see RL4
		.jam(jam), // see RL21
		.ratio(ref_ratio), // see RL9 see RL22
		.count(ref_count),
		.event_out(ref_event),
		.pulse(ref_pulse_raw)
	);

	sdp_divider #(.WIDTH(FB_WIDTH), .PULSE_CYC(PULSE_CYC)) u_fb_div
	(
		.mclk(mclk),
		.rst(rst),
		.tick(vco_tick), // see RL3 see RL4
		.jam(jam), // see RL21
		.ratio(fb_load), // see RL11 see RL22
		.count(fb_count),
		.event_out(fb_event),
		.pulse(fb_pulse_raw)
	);

	// outputs rest low, gated by their enables
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			ref_divided_pulse <= 1'b0;
			feedback_divided_pulse <= 1'b0;
		end
		else
		begin
			ref_divided_pulse <= ref_pulse_raw & cfg.ref_en; // see RL8 see RL12
			feedback_divided_pulse <= fb_pulse_raw & cfg.fb_en; // see RL10 see RL19
		end
	end

	// ---------------- reference clock output ----------------
	logic [3:0] prescale;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			prescale <= 4'h0;
		else if (ref_tick)
			prescale <= prescale + 4'h1;
	end

	logic ref_out_sel;
	always_comb
	begin
		case (cfg.refsel) // see RL18
			sdp_pkg::SDP_REF_LOW: ref_out_sel = 1'b0;
			sdp_pkg::SDP_REF_DIV1: ref_out_sel = ref_lvl; // see RL7
			sdp_pkg::SDP_REF_DIV2: ref_out_sel = prescale[0];
			sdp_pkg::SDP_REF_DIV4: ref_out_sel = prescale[1];
			sdp_pkg::SDP_REF_DIV8: ref_out_sel = prescale[2];
			sdp_pkg::SDP_REF_DIV16: ref_out_sel = prescale[3];
			sdp_pkg::SDP_REF_DIV8B: ref_out_sel = prescale[2];
			sdp_pkg::SDP_REF_DIV16B: ref_out_sel = prescale[3];
			default: ref_out_sel = 1'b0;
		endcase
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			ref_clock_output <= 1'b0;
		else
			ref_clock_output <= ref_out_sel; // see RL6
	end

	// ---------------- phase detector ----------------
	// state per mclk cycle, so even a one-cycle lead gives a pulse
	sdp_pkg::sdp_pd_e next_pd_state;

	always_comb
	begin
		next_pd_state = pd_state;
		case (pd_state) // see RL23
			sdp_pkg::SDP_PD_IDLE:
				if (ref_event & ~fb_event)
					next_pd_state = sdp_pkg::SDP_PD_REF_LEAD;
				else if (fb_event & ~ref_event)
					next_pd_state = sdp_pkg::SDP_PD_FB_LEAD;
			sdp_pkg::SDP_PD_REF_LEAD:
				if (fb_event & ~ref_event)
					next_pd_state = sdp_pkg::SDP_PD_IDLE;
			sdp_pkg::SDP_PD_FB_LEAD:
				if (ref_event & ~fb_event)
					next_pd_state = sdp_pkg::SDP_PD_IDLE;
			default: next_pd_state = sdp_pkg::SDP_PD_IDLE;
		endcase
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			pd_state <= sdp_pkg::SDP_PD_IDLE;
		else if (jam)
			pd_state <= sdp_pkg::SDP_PD_IDLE; // see RL21
		else
			pd_state <= next_pd_state; // see RL16
	end

	// feedback leading drives low, lagging drives high, invert swaps
	wire pd_drive = (pd_state != sdp_pkg::SDP_PD_IDLE) & cfg.select; // see RL15 see RL20
	wire pd_level = (pd_state == sdp_pkg::SDP_PD_REF_LEAD) ^ cfg.invert; // see RL14

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			phase_error_output_o <= 1'b0;
			phase_error_output_oe_n <= 1'b1;
		end
		else
		begin
			phase_error_output_o <= pd_level;
			phase_error_output_oe_n <= ~pd_drive; // see RL17
		end
	end

	// ---------------- serial shift register ----------------
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			shift_reg <= '0;
		else if (~senb_n & sclk_rise)
			shift_reg <= {shift_reg[`SDP_SHIFT_LEN-2:0], sdin_lvl};
	end

	// dout changes on falling serial clock, undriven while disabled
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			ser_dout_o <= 1'b0;
			ser_dout_oe_n <= 1'b1;
		end
		else
		begin
			ser_dout_oe_n <= senb_n;
			if (~senb_n & sclk_fall)
				ser_dout_o <= shift_reg[`SDP_SHIFT_LEN-1]; // see RL1
		end
	end

endmodule : sdp_synth_core

`default_nettype wire

// [verification/sdp_core_sva.sv]
// assertion checker for the divider and phase detector core
`timescale 1ns/1ns
`default_nettype none

module sdp_core_sva
#(
	parameter int PULSE_CYC = 5
)
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic ser_clk,
	input wire logic ser_enable_n,
	input wire logic ser_dout_o,
	input wire logic ser_dout_oe_n,
	input wire logic ref_divided_pulse,
	input wire logic feedback_divided_pulse,
	input wire logic phase_error_output_o,
	input wire logic phase_error_output_oe_n
);
	logic [3:0] ref_hi;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			ref_hi <= 4'h0;
		else
			ref_hi <= ref_divided_pulse ? ref_hi + 4'h1 : 4'h0;
	end
	sequence s_fb_pulse;
		feedback_divided_pulse [*5] ##1 !feedback_divided_pulse;
	endsequence
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus not ready or not okay");
	a_rdata_holds: assert property (!(hsel && htrans[1] && hready)
		|=> $stable(hrdata)) else $error("read data moved");
	a_ref_width: assert property ($fell(ref_divided_pulse) |->
		ref_hi == PULSE_CYC) else $error("ref pulse width");
	a_fb_width: assert property ($rose(feedback_divided_pulse) |->
		s_fb_pulse) else $error("fb pulse width");
	a_reset_quiet: assert property ($fell(rst) |->
		!ref_divided_pulse && !feedback_divided_pulse
		&& phase_error_output_oe_n) else $error("outputs busy after reset");
	a_err_steady: assert property (!phase_error_output_oe_n
		&& $past(!phase_error_output_oe_n) |-> $stable(phase_error_output_o))
		else $error("error level changed while driven");
	a_ser_hiz: assert property (ser_enable_n [*6] |-> ser_dout_oe_n)
		else $error("serial out driven while disabled");
	a_ser_on_fall: assert property (ser_clk [*8] |->
		$stable(ser_dout_o)) else $error("serial out moved with clock high");
endmodule : sdp_core_sva

bind sdp_synth_core sdp_core_sva #(.PULSE_CYC(PULSE_CYC)) u_sva (.mclk, .rst,
	.hsel, .htrans, .hready, .hreadyout, .hresp, .hrdata, .ser_clk,
	.ser_enable_n, .ser_dout_o, .ser_dout_oe_n, .ref_divided_pulse,
	.feedback_divided_pulse, .phase_error_output_o, .phase_error_output_oe_n);

`default_nettype wire

// [verification/sdp_osc_model.sv]
// free-running oscillator standing in for the reference source or the vco
`timescale 1ns/1ns
`default_nettype none

module sdp_osc_model
(
	input wire logic [15:0] half_ns,
	output logic osc
);
	initial osc = 1'b0;
	always
	begin
		#(half_ns);
		osc = ~osc;
	end
endmodule : sdp_osc_model

`default_nettype wire

// [verification/sdp_synth_core_bench.sv]
// self-checking bench for the divider and phase detector core
`timescale 1ns/1ns
`default_nettype none

module sdp_synth_core_bench;
	logic mclk, rst, hsel, hwrite, hready, hreadyout, hresp, lock, vco_input;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic ref_osc, vco_osc, ser_clk, ser_din, ser_enable_n, ser_dout_o;
	logic ser_dout_oe_n, ref_clock_output, ref_divided_pulse;
	logic feedback_divided_pulse, phase_error_output_o, phase_error_output_oe_n;
	logic [16:0] sd;
	// rates keep ref out at 10 MHz and both divided pulses at 2 MHz or less
	logic [15:0] ref_half = 16'd50;
	logic [15:0] vco_half = 16'd30;
	int mismatches, checks_done, cycles, n_clk, n_ref, n_fb, drv0, drv1, r;
	int divs [8] = '{1, 1, 2, 4, 8, 16, 8, 16};
	assign hready = hreadyout;
	assign vco_input = lock ? ref_osc : vco_osc;
	sdp_osc_model u_ref (.half_ns(ref_half), .osc(ref_osc));
	sdp_osc_model u_vco (.half_ns(vco_half), .osc(vco_osc));
	sdp_synth_core u_dut (.mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready, .hreadyout, .hresp, .hrdata, .ref_osc_input(ref_osc),
		.vco_input, .ser_clk, .ser_din, .ser_enable_n, .ser_dout_o,
		.ser_dout_oe_n, .ref_clock_output, .ref_divided_pulse,
		.feedback_divided_pulse, .phase_error_output_o, .phase_error_output_oe_n);
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge ref_clock_output) n_clk++;
	always @(posedge ref_divided_pulse) n_ref++;
	always @(posedge feedback_divided_pulse) n_fb++;
	// sampled away from the launching edge
	always @(negedge mclk)
	begin
		if (phase_error_output_oe_n === 1'b0 && phase_error_output_o === 1'b0)
			drv0++;
		if (phase_error_output_oe_n === 1'b0 && phase_error_output_o === 1'b1)
			drv1++;
	end
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 80000)
		begin
			mismatches++;
			stop_test();
		end
	end
	function automatic int expc(int n, int half, int d);
		return n * 10 / (2 * half * d);
	endfunction : expc
	// counts seen over a window may be off by one partial period
	function automatic logic [31:0] near(int g, int e);
		return (g <= e + 1 && g + 1 >= e) ? 32'h1 : 32'h0;
	endfunction : near
	task automatic stop_test();
		if (mismatches == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e)
		begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic ahb(input logic w, input logic [7:0] a, input int d);
		@(posedge mclk);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		hwrite <= w;
		htrans <= 2'b10;
		hsize <= 3'b010;
		do @(posedge mclk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= 32'(d);
		do @(posedge mclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : ahb
	task automatic window(input int n);
		repeat (300) @(posedge mclk);
		n_clk = 0;
		n_ref = 0;
		n_fb = 0;
		drv0 = 0;
		drv1 = 0;
		repeat (n) @(posedge mclk);
	endtask : window
	// jam both counters, then change enables before any new division ends
	task automatic jam_cfg(input int fb, input int c);
		ahb(1'b1, 8'h08, fb);
		repeat (8) @(posedge mclk);
		ahb(1'b1, 8'h00, c);
	endtask : jam_cfg
	initial
	begin
		rst = 1'b1;
		{hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
		{lock, ser_clk, ser_din} = 3'b000;
		ser_enable_n = 1'b1;
		void'($urandom(23683));
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		ahb(1'b0, 8'h00, 0);
		chk(rd, 32'h10);
		ahb(1'b0, 8'h04, 0);
		chk(rd, 32'h5);
		ahb(1'b0, 8'h08, 0);
		chk(rd, 32'h28);
		ahb(1'b1, 8'h1C, -1);
		ahb(1'b0, 8'h1C, 0);
		chk(rd, 32'h0);
		window(500);
		chk(near(n_clk, expc(500, ref_half, 8)), 32'h1);
		chk(32'(n_ref + n_fb), 32'h0);
		for (int s = 0; s < 8; s++)
		begin
			ahb(1'b1, 8'h00, s << 2);
			window(500);
			r = s == 0 ? 0 : expc(500, ref_half, divs[s]);
			chk(near(n_clk, r), 32'h1);
		end
		jam_cfg(40, 3);
		for (int t = 0; t < 3; t++)
		begin
			r = t == 0 ? 5 : 5 + $urandom % 8;
			ahb(1'b1, 8'h04, r);
			window(2000);
			chk(near(n_ref, expc(2000, ref_half, r)), 32'h1);
			chk(32'(n_clk), 32'h0);
			r = 40 + $urandom % 8;
			ahb(1'b1, 8'h08, r);
			window(3000);
			chk(near(n_fb, expc(3000, vco_half, r)), 32'h1);
		end
		for (int p = 0; p < 4; p++)
		begin
			ahb(1'b1, 8'h04, p[1] ? 40 : 5);
			jam_cfg(40, 32'h40 | (p[0] << 7));
			window(3000);
			r = {drv0 > 0, drv1 > 0};
			chk(32'(r), (p[1] ^ p[0]) ? 32'h2 : 32'h1);
		end
		ahb(1'b1, 8'h00, 32'h80);
		window(1000);
		chk(32'(drv0 + drv1), 32'h0);
		lock <= 1'b1;
		ahb(1'b1, 8'h04, 40);
		ahb(1'b1, 8'h00, 32'h40);
		ahb(1'b1, 8'h08, 40);
		window(3000);
		chk(32'(drv0 + drv1), 32'h0);
		sd = 17'($urandom);
		ser_enable_n <= 1'b0;
		for (int k = 0; k < 33; k++)
		begin
			ser_din <= k < 17 ? sd[16 - k] : 1'b0;
			repeat (10) @(posedge mclk);
			ser_clk <= 1'b1;
			repeat (10) @(posedge mclk);
			ser_clk <= 1'b0;
			repeat (10) @(posedge mclk);
			if (k >= 16)
				chk({31'h0, ser_dout_o}, {31'h0, sd[32 - k]});
		end
		chk({31'h0, ser_dout_oe_n}, 32'h0);
		ser_enable_n <= 1'b1;
		repeat (10) @(posedge mclk);
		stop_test();
	end
endmodule : sdp_synth_core_bench

`default_nettype wire
